/* hdl/ssq_fifo.sv */
// Sample FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ssq_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 32
) (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } ssq_fifo_st_t;

   ssq_fifo_st_t s_r;
   ssq_fifo_st_t s_nxt;
   logic [W-1:0] mem [DEPTH];
   logic         push;
   logic         pop;

   assign o_in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
   assign o_out_valid = (s_r.cnt != '0);
   assign o_out_data  = mem[s_r.rd];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.wr = (s_r.wr == AW'(DEPTH - 1)) ? '0 : s_r.wr + 1'b1;
      end
      if (pop) begin
         s_nxt.rd = (s_r.rd == AW'(DEPTH - 1)) ? '0 : s_r.rd + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[s_r.wr] <= i_in_data;
      end
   end
endmodule : ssq_fifo
`default_nettype wire

/* hdl/ssq_seq.sv */
// Interleaved dual sensor scan sequencer
//
// Contract
// - Paired scan delivers twice the single sensor pixel count.
// - Selection swaps sensor every pixel, not once per scan.
// - Paired readout starts only on scan_begin, then runs continuously; the code holds at a half-pixel boundary while a sample waits on a full FIFO.
// - Each pixel cycle addresses both sensors in fixed order, one clock each.
// - Scan completes only after both sensors report scan_finish; the code also ends it on a fault (early secondary finish or LAG_MAX lag).
// - Combined mode selects: 00 channel 1 alone, 01/10/11 pair with 2/3/4.
// - Sequential mode: sequencer idle, selects drive multiplexers directly.
// - Main sensor clocked first, then all secondaries together once.
// - Multiplexer addresses toggle main/secondary in step with sensor clock.
// - Sample scan_finish each pixel cycle; active finish blocks further storage.
// - Accept finishes in channel order, possibly in different pixel cycles.
// - Success shows a finish pulse per active channel in final cycle.
// - On fault forward finish pulses only up to the first missing one.
// - Per cycle pixel n of sensor 1 precedes pixel n of sensor 2.
// - Finish and trigger status follow the same select as video.
// - All sensors get scan stimulus synchronously whatever pair is chosen.
// - Samples of unselected sensors are discarded.
// - Both active sensors share one integration time per scan.
// - Second sensor lags the first by half a pixel readout period.
// - Sequential selects 00 through 11 pick channel 1 through 4.
// - Scan start and pixel clock go to all sensors; only selected returns.
`timescale 1ns/1ps
`default_nettype none
module ssq_seq
   import ssq_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_scan_combine_mode,
   input  wire logic              i_chan_select_lo,
   input  wire logic              i_chan_select_hi,
   input  wire logic              i_scan_begin,
   input  wire logic              i_scan_finish,
   input  wire logic              i_trigger,
   input  wire logic              i_adc_valid,
   input  wire logic [DATA_W-1:0] i_adc_data,
   input  wire logic              i_out_ready,
   output logic                   o_scan_start,
   output logic                   o_main_pix_clk,
   output logic                   o_sec_pix_clk,
   output logic [1:0]             o_mux_addr,
   output logic                   o_store_en,
   output logic                   o_scan_finish,
   output logic                   o_trigger,
   output logic                   o_busy,
   output logic                   o_fault,
   output logic [FCNT_W-1:0]      o_frame_pixels,
   output logic                   o_out_valid,
   output logic [DATA_W-1:0]      o_out_data
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [4:0]        sync1;
      logic [4:0]        sync2;
      ssq_state_t        st;
      logic [HCNT_W-1:0] hcnt;
      logic [1:0]        sel;
      logic              pair;
      logic              main_seen;
      logic              sec_seen;
      logic              fault;
      logic [2:0]        lag;
      logic              got;
      logic              pend;
      logic [DATA_W-1:0] sample;
      logic [FCNT_W-1:0] fcnt;
      logic [FCNT_W-1:0] frame;
      logic              start;
      logic              main_clk;
      logic              sec_clk;
      logic [1:0]        addr;
      logic              fin_out;
   } ssq_st_t;

   ssq_st_t    s_r;
   ssq_st_t    s_nxt;
   logic       mode_s;
   logic [1:0] sel_s;
   logic       fin_s;
   logic       fifo_ready;
   logic       store_ok;
   logic       half_end;

   assign mode_s = s_r.sync2[0];
   assign sel_s  = {s_r.sync2[2], s_r.sync2[1]};
   assign fin_s  = s_r.sync2[3];

   // Storage window closes per channel once its finish was seen
   assign store_ok = (s_r.st == ST_MAIN && !s_r.main_seen) ||
                     (s_r.st == ST_SEC && !s_r.sec_seen && !s_r.fault);
   assign half_end = (s_r.hcnt == HALF_LAST) && !s_r.pend;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_nxt       = s_r;
      s_nxt.sync1 = {i_trigger, i_scan_finish, i_chan_select_hi, i_chan_select_lo,
                     i_scan_combine_mode};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.hcnt  = (s_r.hcnt == HALF_LAST) ? s_r.hcnt : s_r.hcnt + 1'b1;

      // Sample capture and hand-off to FIFO
      if (s_r.pend && fifo_ready) begin
         s_nxt.pend = 1'b0;
         s_nxt.fcnt = s_r.fcnt + FCNT_ONE;
      end
      if (store_ok && i_adc_valid && !s_r.got) begin
         s_nxt.got    = 1'b1;
         s_nxt.pend   = 1'b1;
         s_nxt.sample = i_adc_data;
      end

      unique case (s_r.st)
         ST_IDLE: begin
            if (mode_s && i_scan_begin) begin
               s_nxt.st        = ST_START;
               s_nxt.hcnt      = '0;
               s_nxt.sel       = sel_s;
               s_nxt.pair      = (sel_s != SEL_SINGLE);
               s_nxt.main_seen = 1'b0;
               s_nxt.sec_seen  = 1'b0;
               s_nxt.fault     = 1'b0;
               s_nxt.lag       = '0;
               s_nxt.fcnt      = '0;
            end
         end
         ST_START: begin
            if (s_r.hcnt == START_HIGH) begin
               s_nxt.st   = ST_MAIN;
               s_nxt.hcnt = '0;
               s_nxt.got  = 1'b0;
            end
         end
         ST_MAIN: begin
            if (half_end) begin
               s_nxt.hcnt = '0;
               s_nxt.got  = 1'b0;
               if (fin_s) begin
                  s_nxt.main_seen = 1'b1;
               end
               if (s_r.pair) begin
                  s_nxt.st = ST_SEC;
               end else if (fin_s || s_r.main_seen) begin
                  s_nxt.st = ST_FIN_MAIN;
               end
            end
         end
         ST_SEC: begin
            if (half_end) begin
               s_nxt.hcnt = '0;
               s_nxt.got  = 1'b0;
               s_nxt.st   = ST_MAIN;
               if (fin_s && s_r.main_seen) begin
                  s_nxt.sec_seen = 1'b1;
               end else if (fin_s) begin
                  s_nxt.fault = 1'b1;
               end else if (s_r.main_seen) begin
                  s_nxt.lag = s_r.lag + 3'h1;
               end
               if ((fin_s && s_r.main_seen) || fin_s || (s_r.lag == LAG_MAX)) begin
                  s_nxt.st = ST_FIN_MAIN;
               end
               if (!fin_s && s_r.main_seen && s_r.lag == LAG_MAX) begin
                  s_nxt.fault = 1'b1;
               end
            end
         end
         ST_FIN_MAIN: begin
            if (s_r.hcnt >= CLK_HIGH && !s_r.pend) begin
               s_nxt.hcnt = '0;
               s_nxt.st   = s_r.pair ? ST_FIN_SEC : ST_IDLE;
               if (!s_r.pair) begin
                  s_nxt.frame = s_r.fcnt;
               end
            end
         end
         ST_FIN_SEC: begin
            if (s_r.hcnt >= CLK_HIGH && !s_r.pend) begin
               s_nxt.st    = ST_IDLE;
               s_nxt.frame = s_r.fcnt;
            end
         end
      endcase

      // Registered pin drive from the next state
      s_nxt.start    = (s_nxt.st == ST_START);
      s_nxt.main_clk = (s_nxt.st == ST_MAIN) && (s_nxt.hcnt < CLK_HIGH);
      s_nxt.sec_clk  = (s_nxt.st == ST_SEC) && (s_nxt.hcnt < CLK_HIGH);
      if (s_nxt.st == ST_IDLE) begin
         s_nxt.addr = mode_s ? CH_MAIN : sel_s;
      end else if (s_nxt.st == ST_SEC || s_nxt.st == ST_FIN_SEC) begin
         s_nxt.addr = s_nxt.sel;
      end else begin
         s_nxt.addr = CH_MAIN;
      end
      s_nxt.fin_out = (((s_nxt.st == ST_FIN_MAIN) && s_nxt.main_seen) ||
                       ((s_nxt.st == ST_FIN_SEC) && s_nxt.sec_seen)) &&
                      (s_nxt.hcnt < CLK_HIGH);
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_r      <= '0;
         s_r.st   <= ST_IDLE;
         s_r.addr <= CH_MAIN;
      end else begin
         s_r      <= s_nxt;
      end
   end

   // Trigger from the digital selector, already switched with video
   assign o_trigger      = s_r.sync2[4];
   assign o_scan_start   = s_r.start;
   assign o_main_pix_clk = s_r.main_clk;
   assign o_sec_pix_clk  = s_r.sec_clk;
   assign o_mux_addr     = s_r.addr;
   assign o_store_en     = store_ok;
   assign o_scan_finish  = s_r.fin_out;
   assign o_busy         = (s_r.st != ST_IDLE);
   assign o_fault        = s_r.fault;
   assign o_frame_pixels = s_r.frame;

   // ****************************************
   // Sample FIFO, main then secondary order
   // ****************************************
   ssq_fifo #(
      .W     (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) ssq_fifo_i (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (s_r.pend),
      .o_in_ready  (fifo_ready),
      .i_in_data   (s_r.sample),
      .o_out_valid (o_out_valid),
      .i_out_ready (i_out_ready),
      .o_out_data  (o_out_data)
   );

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_main_half;
      s_r.st == ST_MAIN && half_end && s_r.pair;
   endsequence

   sequence s_sec_half;
      s_r.st == ST_SEC;
   endsequence

   property p_begin_only;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_r.st == ST_IDLE && !(mode_s && i_scan_begin)) |=> s_r.st == ST_IDLE;
   endproperty
   a_begin_only: assert property (p_begin_only) else $error("scan left idle without begin");

   property p_alternate;
      @(posedge i_clk) disable iff (i_sys_rst)
      s_main_half |=> s_sec_half;
   endproperty
   a_alternate: assert property (p_alternate) else $error("no secondary half after main");

   property p_addr_follows;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_r.st == ST_SEC) |-> (o_mux_addr == s_r.sel) && !o_main_pix_clk;
   endproperty
   a_addr_follows: assert property (p_addr_follows) else $error("secondary address wrong");

   property p_static_sel;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_r.st == ST_IDLE && !mode_s) ##1 (s_r.st == ST_IDLE) |-> o_mux_addr == $past(sel_s);
   endproperty
   a_static_sel: assert property (p_static_sel) else $error("static select not applied");

   property p_store_block;
      @(posedge i_clk) disable iff (i_sys_rst)
      (s_r.st == ST_MAIN && s_r.main_seen) |-> !o_store_en && !s_r.got;
   endproperty
   a_store_block: assert property (p_store_block) else $error("storage after finish");

   property p_main_first;
      @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_main_pix_clk) |-> (o_mux_addr == CH_MAIN) && !o_sec_pix_clk;
   endproperty
   a_main_first: assert property (p_main_first) else $error("main clock on wrong address");

   property p_success_pulse;
      @(posedge i_clk) disable iff (i_sys_rst)
      (o_scan_finish && s_r.st == ST_FIN_SEC) |-> s_r.main_seen && s_r.sec_seen;
   endproperty
   a_success_pulse: assert property (p_success_pulse) else $error("bad second finish pulse");

   property p_fault_stop;
      @(posedge i_clk) disable iff (i_sys_rst)
      s_r.fault |-> !(o_scan_finish && (s_r.st == ST_FIN_SEC || !s_r.main_seen));
   endproperty
   a_fault_stop: assert property (p_fault_stop) else $error("finish forwarded after fault");

   property p_start_sync;
      @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_scan_start) |=> o_scan_start [*3] ##1 !o_main_pix_clk;
   endproperty
   a_start_sync: assert property (p_start_sync) else $error("scan start pulse too short");

endmodule : ssq_seq
`default_nettype wire

/* pkg/ssq_pkg.sv */
// Constants, states and helpers shared by the dual sensor scan sequencer
package ssq_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS  = 4000;
   localparam int PIXEL_TIME_NS  = 5300;
   localparam int CLK_HIGH_NS    = 100;
   localparam int START_HIGH_NS  = 100;

   function automatic int ssq_cyc_up(input int t_ns);
      int c;
      c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : ssq_cyc_up

   localparam int PIXEL_CYC      = (PIXEL_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int HALF_CYC       = PIXEL_CYC / 2;
   localparam int HCNT_W         = 11;
   localparam logic [HCNT_W-1:0] HALF_LAST  = HCNT_W'(HALF_CYC - 1);
   localparam logic [HCNT_W-1:0] CLK_HIGH   = HCNT_W'(ssq_cyc_up(CLK_HIGH_NS));
   localparam logic [HCNT_W-1:0] START_HIGH = HCNT_W'(ssq_cyc_up(START_HIGH_NS));

   // ****************************************
   // Widths and codes
   // ****************************************
   localparam int DATA_W     = 16;
   localparam int FIFO_DEPTH = 32;
   localparam int FCNT_W     = 16;
   localparam logic [2:0] LAG_MAX    = 3'h4;
   localparam logic [1:0] CH_MAIN    = 2'h0;
   localparam logic [1:0] SEL_SINGLE = 2'h0;
   localparam logic [FCNT_W-1:0] FCNT_ONE = 16'h0001;

   typedef enum logic [5:0] {
      ST_IDLE     = 6'h01,
      ST_START    = 6'h02,
      ST_MAIN     = 6'h04,
      ST_SEC      = 6'h08,
      ST_FIN_MAIN = 6'h10,
      ST_FIN_SEC  = 6'h20
   } ssq_state_t;

endpackage : ssq_pkg

/* verif/ssq_sensor_model.sv */
// Behavioural model of four sensors behind the video and status selectors
`timescale 1ns/1ps
`default_nettype none
module ssq_sensor_model
   import ssq_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_scan_start,
   input  wire logic              i_main_pix_clk,
   input  wire logic              i_sec_pix_clk,
   input  wire logic [1:0]        i_mux_addr,
   input  wire logic [7:0]        i_lag,
   input  wire logic [7:0]        i_npix_main,
   input  wire logic [7:0]        i_npix_sec,
   output logic                   o_scan_finish,
   output logic                   o_trigger,
   output logic                   o_adc_valid,
   output logic [DATA_W-1:0]      o_adc_data
);
   logic [7:0] cnt_r [4];
   logic [3:0] fin;
   logic       start_q;
   logic       main_q;
   logic       sec_q;
   logic [8:0] conv_r;

   // ****************************************
   // Pixel counters and converter
   // ****************************************
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_r       <= '{default: 8'h00};
         start_q     <= 1'b0;
         main_q      <= 1'b0;
         sec_q       <= 1'b0;
         conv_r      <= 9'h000;
         o_adc_valid <= 1'b0;
         o_adc_data  <= 16'h5A5A;
      end else begin
         start_q     <= i_scan_start;
         main_q      <= i_main_pix_clk;
         sec_q       <= i_sec_pix_clk;
         o_adc_valid <= 1'b0;
         o_adc_data  <= ~o_adc_data;
         if (conv_r != 9'h000) begin
            conv_r <= conv_r - 9'h001;
         end
         if (i_scan_start && !start_q) begin
            cnt_r <= '{default: 8'h00};
         end
         if (i_main_pix_clk && !main_q) begin
            cnt_r[0] <= cnt_r[0] + 8'h01;
            conv_r   <= {1'b0, i_lag};
         end
         if (i_sec_pix_clk && !sec_q) begin
            for (int c = 1; c < 4; c++) begin
               cnt_r[c] <= cnt_r[c] + 8'h01;
            end
            conv_r <= {1'b0, i_lag};
         end
         if (conv_r == 9'h001) begin
            o_adc_valid <= 1'b1;
            o_adc_data  <= {6'h00, i_mux_addr, cnt_r[i_mux_addr]};
         end
      end
   end

   // ****************************************
   // Finish levels through the status selector
   // ****************************************
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         fin[c] = cnt_r[c] >= ((c == 0) ? i_npix_main : i_npix_sec);
      end
   end
   assign o_scan_finish = fin[i_mux_addr];
   assign o_trigger     = o_adc_valid;
endmodule : ssq_sensor_model
`default_nettype wire

/* verif/ssq_seq_bench.sv */
// Self-checking bench for the dual sensor scan sequencer
`timescale 1ns/1ps
`default_nettype none
module ssq_seq_bench
   import ssq_pkg::*;
;
   logic clk, rst, mode, sel_lo, sel_hi, scan_begin, out_ready;
   logic scan_fin, trig, adc_valid, scan_start, main_clk, sec_clk, store_en;
   logic fin_out, trig_out, busy, fault, out_valid, fin_q, main_q, sec_q, trig_q1, trig_q2;
   logic [DATA_W-1:0] adc_data, out_data;
   logic [FCNT_W-1:0] frame_pix;
   logic [1:0]        mux_addr, cur_sel;
   logic [7:0]        npix_main, npix_sec, lag_r;
   logic [15:0]       words [$];
   logic [1:0]        fin_addr [$];
   int                n_errors, checks_done, cycles;

   ssq_seq ssq_seq_i (.i_clk(clk), .i_sys_rst(rst), .i_scan_combine_mode(mode),
      .i_chan_select_lo(sel_lo), .i_chan_select_hi(sel_hi), .i_scan_begin(scan_begin),
      .i_scan_finish(scan_fin), .i_trigger(trig), .i_adc_valid(adc_valid),
      .i_adc_data(adc_data), .i_out_ready(out_ready), .o_scan_start(scan_start),
      .o_main_pix_clk(main_clk), .o_sec_pix_clk(sec_clk), .o_mux_addr(mux_addr),
      .o_store_en(store_en), .o_scan_finish(fin_out), .o_trigger(trig_out), .o_busy(busy),
      .o_fault(fault), .o_frame_pixels(frame_pix), .o_out_valid(out_valid),
      .o_out_data(out_data));

   ssq_sensor_model ssq_sensor_model_i (.i_clk(clk), .i_sys_rst(rst),
      .i_scan_start(scan_start), .i_main_pix_clk(main_clk), .i_sec_pix_clk(sec_clk),
      .i_mux_addr(mux_addr), .i_lag(lag_r), .i_npix_main(npix_main),
      .i_npix_sec(npix_sec), .o_scan_finish(scan_fin), .o_trigger(trig),
      .o_adc_valid(adc_valid), .o_adc_data(adc_data));

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic finish_test;
      $display("Checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // ****************************************
   // Monitors
   // ****************************************
   always @(posedge clk) begin
      fin_q   <= fin_out;
      main_q  <= main_clk;
      sec_q   <= sec_clk;
      trig_q1 <= rst ? 1'b0 : trig;
      trig_q2 <= rst ? 1'b0 : trig_q1;
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         words.push_back(out_data);
      end
      if (fin_out === 1'b1 && fin_q !== 1'b1) begin
         fin_addr.push_back(mux_addr);
      end
      if (main_clk === 1'b1 && main_q !== 1'b1) begin
         chk("main clock address", 16'(CH_MAIN), 16'(mux_addr));
      end
      if (sec_clk === 1'b1 && sec_q !== 1'b1) begin
         chk("secondary clock address", 16'(cur_sel), 16'(mux_addr));
      end
      if (main_clk === 1'b1 && sec_clk === 1'b1) begin
         chk("clock overlap", 16'h0000, 16'h0001);
      end
      if (rst === 1'b0) begin
         chk("trigger route", 16'(trig_q2), 16'(trig_out));
      end
      cycles++;
      if (cycles == 90000) begin
         n_errors++;
         $display("CHECK FAILED run length expected below 90000 seen 90000");
         finish_test();
      end
   end

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic seq_modes;
      mode <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         {sel_hi, sel_lo} <= 2'(s);
         repeat (5) @(posedge clk);
         chk("static address", 16'(s), 16'(mux_addr));
         chk("storage in sequential", 16'h0000, 16'(store_en));
         scan_begin <= 1'b1;
         @(posedge clk);
         scan_begin <= 1'b0;
         repeat (30) @(posedge clk);
         chk("busy in sequential", 16'h0000, 16'(busy));
         chk("clock in sequential", 16'h0000, 16'(main_clk));
      end
   endtask : seq_modes

   task automatic run_scan(input logic [1:0] sel, input logic [7:0] nm, input logic [7:0] ns,
                           input logic [7:0] lag, input bit stall, input bit bad);
      logic [15:0] exp [$];
      int          n;
      n = 0;
      for (int p = 1; p <= 17; p++) begin
         if (p <= nm) exp.push_back({6'h00, CH_MAIN, 8'(p)});
         if (sel != SEL_SINGLE && p <= ns) exp.push_back({6'h00, sel, 8'(p)});
      end
      mode <= 1'b1;
      {sel_hi, sel_lo} <= sel;
      npix_main <= nm;
      npix_sec <= ns;
      lag_r <= lag;
      out_ready <= !stall;
      repeat (6) @(posedge clk);
      chk("start before begin", 16'h0000, 16'(scan_start));
      words.delete();
      fin_addr.delete();
      cur_sel = sel;
      scan_begin <= 1'b1;
      @(posedge clk);
      scan_begin <= 1'b0;
      while (stall && n < 33) begin
         @(posedge clk);
         if (adc_valid === 1'b1 && store_en === 1'b1) n++;
      end
      if (stall) begin
         repeat (100) @(posedge clk);
         chk("busy while full", 16'h0001, 16'(busy));
         chk("words while stalled", 16'h0000, 16'(words.size()));
         out_ready <= 1'b1;
      end
      @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
      repeat (20) @(posedge clk);
      chk("fault flag", 16'(bad), 16'(fault));
      if (bad) begin
         chk("pulses after fault", 16'((nm < ns) ? 1 : 0), 16'(fin_addr.size()));
      end else begin
         chk("frame pixels", 16'(exp.size()), frame_pix);
         chk("word count", 16'(exp.size()), 16'(words.size()));
         foreach (exp[i]) if (i < words.size()) chk("sample word", exp[i], words[i]);
         chk("finish pulses", 16'((sel == SEL_SINGLE) ? 1 : 2), 16'(fin_addr.size()));
         foreach (fin_addr[i]) chk("finish address", (i == 0) ? 16'(CH_MAIN) : 16'(sel),
                                   16'(fin_addr[i]));
      end
   endtask : run_scan

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      {rst, mode, sel_lo, sel_hi, scan_begin, out_ready} = 6'b100001;
      {npix_main, npix_sec, lag_r} = {8'h03, 8'h03, 8'h1E};
      {n_errors, checks_done, cycles} = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("reset address", 16'h0000, 16'(mux_addr));
      chk("reset storage", 16'h0000, 16'(store_en));
      chk("reset busy", 16'h0000, 16'(busy));
      seq_modes();
      run_scan(2'h1, 8'h03, 8'h03, 8'h1E, 1'b0, 1'b0);
      run_scan(2'h2, 8'h03, 8'h03, 8'hC8, 1'b0, 1'b0);
      run_scan(2'h3, 8'h03, 8'h05, 8'h1E, 1'b0, 1'b0);
      run_scan(2'h0, 8'h03, 8'h03, 8'h1E, 1'b0, 1'b0);
      run_scan(2'h1, 8'h05, 8'h03, 8'h1E, 1'b0, 1'b1);
      run_scan(2'h1, 8'h03, 8'h09, 8'h1E, 1'b0, 1'b1);
      run_scan(2'h2, 8'h11, 8'h11, 8'h1E, 1'b1, 1'b0);
      finish_test();
   end
endmodule : ssq_seq_bench
`default_nettype wire
